// ==== hw/bsf_params.svh ====
// Contract
// - Bit-set forces the chosen bit of the file register high, others kept.
// - Access bit zero resolves the file address inside the access bank, except in the indexed case below.
// - Access bit one takes the bank from the bank pointer register.
// - Extended set, access zero, address up to 5Fh: indexed literal offset.
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH

`define OPC_HI          15
`define OPC_LO          12
`define OPC_BIT_SET     4'h8
`define JMP_HI          15
`define JMP_LO          11
`define OPC_REL_JUMP    5'h1a
`define BIT_HI          11
`define BIT_LO          9
`define ACC_BIT         8
`define FADDR_HI        7
`define FADDR_LO        0
`define OFS_HI          10
`define OFS_LO          0
`define OFS_SIGN        10
`define IDX_LIMIT       8'h5f
`define ACC_LOW_BANK    4'h0
`define ACC_HIGH_BANK   4'hf
`define PC_STEP         21'h00_0002
`define ONE_BIT         8'h01

`define PH_Q1           2'h0
`define PH_Q2           2'h1
`define PH_Q3           2'h3
`define PH_Q4           2'h2

`endif

// ==== hw/bsf_pkg.sv ====
`include "bsf_params.svh"

package bsf_pkg;

  // Quarter phases of one instruction cycle, Gray coded in order.
  typedef enum logic [1:0] {
    PH_Q1 = `PH_Q1,
    PH_Q2 = `PH_Q2,
    PH_Q3 = `PH_Q3,
    PH_Q4 = `PH_Q4
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_BIT_SET,
    OP_REL_JUMP
  } op_t;

endpackage : bsf_pkg

// ==== hw/bit_set_and_branch_exec.sv ====
`timescale 1ns/1ps
`include "bsf_params.svh"

module bit_set_and_branch_exec #(
  parameter int ADDR_W = 12,
  parameter int PC_W   = 21
) (
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  input  wire logic [15:0]       instr_in,
  input  wire logic              instr_valid_in,
  input  wire logic              ext_set_en_in,
  input  wire logic [3:0]        bank_pointer_register_in,
  input  wire logic [ADDR_W-1:0] index_base_in,
  input  wire logic [PC_W-1:0]   pc_in,
  input  wire logic [7:0]        mem_rdata_in,
  output logic [1:0]             phase_out,
  output logic                   instr_taken_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic                   mem_rd_out,
  output logic                   mem_wr_out,
  output logic [7:0]             mem_wdata_out,
  output logic                   pc_load_out,
  output logic [PC_W-1:0]        pc_target_out,
  output logic                   busy_out
);

  bsf_pkg::phase_t   phase_reg, phase_next;
  bsf_pkg::op_t      op_reg, op_next;
  logic [2:0]        bit_idx_reg, bit_idx_next;
  logic              flush_reg, flush_next;
  logic              taken_reg, taken_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              rd_reg, rd_next;
  logic              wr_reg, wr_next;
  logic [7:0]        wdata_reg, wdata_next;
  logic              pc_load_reg, pc_load_next;
  logic [PC_W-1:0]   pc_tgt_reg, pc_tgt_next;
  logic              take;

  // Resolves the data memory address of a file operand.
  function automatic logic [ADDR_W-1:0] file_addr(
    input logic [7:0]        f,
    input logic              acc,
    input logic              ext,
    input logic [3:0]        bank,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] res;
    res = '0;
    if (acc) begin
      res = ADDR_W'({bank, f});
    end else if (ext && f <= `IDX_LIMIT) begin
      res = base + ADDR_W'(f);
    end else if (f <= `IDX_LIMIT) begin
      res = ADDR_W'({`ACC_LOW_BANK, f});
    end else begin
      res = ADDR_W'({`ACC_HIGH_BANK, f});
    end
    return res;
  endfunction : file_addr

  // A branch keeps the second instruction cycle as a bubble, so the word
  // offered then is not taken and must be held by the fetch path.
  assign take = (phase_reg == bsf_pkg::PH_Q1) && instr_valid_in && !flush_reg;

  always_comb begin
    phase_next   = phase_reg;
    op_next      = op_reg;
    bit_idx_next = bit_idx_reg;
    flush_next   = flush_reg;
    taken_next   = 1'b0;
    addr_next    = addr_reg;
    rd_next      = 1'b0;
    wr_next      = 1'b0;
    wdata_next   = wdata_reg;
    pc_load_next = 1'b0;
    pc_tgt_next  = pc_tgt_reg;
    case (phase_reg)
      bsf_pkg::PH_Q1: begin
        phase_next = bsf_pkg::PH_Q2;
        flush_next = 1'b0;
        op_next    = bsf_pkg::OP_NONE;
        if (take) begin
          taken_next = 1'b1;
          if (instr_in[`OPC_HI:`OPC_LO] == `OPC_BIT_SET) begin
            op_next      = bsf_pkg::OP_BIT_SET;
            bit_idx_next = instr_in[`BIT_HI:`BIT_LO];
            addr_next    = file_addr(instr_in[`FADDR_HI:`FADDR_LO],
                                     instr_in[`ACC_BIT], ext_set_en_in,
                                     bank_pointer_register_in, index_base_in);
            rd_next      = 1'b1;
          end else if (instr_in[`JMP_HI:`JMP_LO] == `OPC_REL_JUMP) begin
            op_next     = bsf_pkg::OP_REL_JUMP;
            // The target wraps inside the program counter width on purpose.
            pc_tgt_next = PC_W'(pc_in + PC_W'(`PC_STEP) + PC_W'({{(PC_W-12){
                            instr_in[`OFS_SIGN]}}, instr_in[`OFS_HI:`OFS_LO],
                            1'b0}));
          end
        end
      end
      bsf_pkg::PH_Q2: begin
        phase_next = bsf_pkg::PH_Q3;
      end
      bsf_pkg::PH_Q3: begin
        phase_next = bsf_pkg::PH_Q4;
        if (op_reg == bsf_pkg::OP_BIT_SET) begin
          wdata_next = mem_rdata_in | (`ONE_BIT << bit_idx_reg);
          wr_next    = 1'b1;
        end else if (op_reg == bsf_pkg::OP_REL_JUMP) begin
          pc_load_next = 1'b1;
          flush_next   = 1'b1;
        end
      end
      bsf_pkg::PH_Q4: begin
        phase_next = bsf_pkg::PH_Q1;
      end
      default: begin
        phase_next = bsf_pkg::PH_Q1;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase_reg   <= bsf_pkg::PH_Q1;
      op_reg      <= bsf_pkg::OP_NONE;
      bit_idx_reg <= '0;
      flush_reg   <= 1'b0;
      taken_reg   <= 1'b0;
      addr_reg    <= '0;
      rd_reg      <= 1'b0;
      wr_reg      <= 1'b0;
      wdata_reg   <= '0;
      pc_load_reg <= 1'b0;
      pc_tgt_reg  <= '0;
    end else begin
      phase_reg   <= phase_next;
      op_reg      <= op_next;
      bit_idx_reg <= bit_idx_next;
      flush_reg   <= flush_next;
      taken_reg   <= taken_next;
      addr_reg    <= addr_next;
      rd_reg      <= rd_next;
      wr_reg      <= wr_next;
      wdata_reg   <= wdata_next;
      pc_load_reg <= pc_load_next;
      pc_tgt_reg  <= pc_tgt_next;
    end
  end

  assign phase_out       = phase_reg;
  assign instr_taken_out = taken_reg;
  assign mem_addr_out    = addr_reg;
  assign mem_rd_out      = rd_reg;
  assign mem_wr_out      = wr_reg;
  assign mem_wdata_out   = wdata_reg;
  assign pc_load_out     = pc_load_reg;
  assign pc_target_out   = pc_tgt_reg;
  assign busy_out        = flush_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  logic [15:0] instr_q;
  logic        ext_q;
  logic [3:0]  bank_q;
  logic [ADDR_W-1:0] base_q;
  always_ff @(posedge mclk_in) begin
    instr_q <= instr_in;
    ext_q   <= ext_set_en_in;
    bank_q  <= bank_pointer_register_in;
    base_q  <= index_base_in;
  end

  a_bit_set_write: assert property (
    (phase_reg == bsf_pkg::PH_Q3 && op_reg == bsf_pkg::OP_BIT_SET) |=>
      mem_wr_out && mem_wdata_out == ($past(mem_rdata_in) |
        (`ONE_BIT << bit_idx_reg)))
    else $error("bit-set write data wrong");

  a_access_bank_addr: assert property (
    (mem_rd_out && !instr_q[`ACC_BIT] &&
     !(ext_q && instr_q[`FADDR_HI:`FADDR_LO] <= `IDX_LIMIT)) |->
      mem_addr_out[`FADDR_HI:`FADDR_LO] == instr_q[`FADDR_HI:`FADDR_LO] &&
      mem_addr_out[ADDR_W-1:8] == ((instr_q[7:0] <= `IDX_LIMIT) ?
        `ACC_LOW_BANK : `ACC_HIGH_BANK))
    else $error("access bank address wrong");

  a_bank_ptr_addr: assert property (
    (mem_rd_out && instr_q[`ACC_BIT]) |->
      mem_addr_out == ADDR_W'({bank_q, instr_q[`FADDR_HI:`FADDR_LO]}))
    else $error("bank pointer address wrong");

  a_indexed_addr: assert property (
    (mem_rd_out && !instr_q[`ACC_BIT] && ext_q &&
     instr_q[`FADDR_HI:`FADDR_LO] <= `IDX_LIMIT) |->
      mem_addr_out == base_q + ADDR_W'(instr_q[`FADDR_HI:`FADDR_LO]))
    else $error("indexed offset address wrong");

  a_one_cycle_set: assert property (
    (take && instr_in[`OPC_HI:`OPC_LO] == `OPC_BIT_SET) |=>
      mem_rd_out ##2 mem_wr_out ##1 (phase_reg == bsf_pkg::PH_Q1 && !busy_out))
    else $error("bit-set not done in one cycle");

  // The bubble only has to cover the single Q1 edge of the second cycle.
  a_jump_bubble: assert property (
    pc_load_out |-> busy_out ##1 (busy_out && phase_reg == bsf_pkg::PH_Q1)
      ##1 !busy_out)
    else $error("jump bubble length wrong");

  c_bit_set_access: cover property (mem_wr_out && !instr_q[`ACC_BIT]);
  c_bit_set_indexed: cover property (mem_rd_out && ext_q &&
    !instr_q[`ACC_BIT] && instr_q[7:0] <= `IDX_LIMIT);
  c_jump_then_set: cover property (pc_load_out ##[1:12] mem_wr_out);
  c_jump_refused: cover property (busy_out && instr_valid_in &&
    phase_reg == bsf_pkg::PH_Q1);

endmodule : bit_set_and_branch_exec

// ==== verif/tb_bit_set_and_branch_exec.sv ====
`timescale 1ns/1ps

module tb_bit_set_and_branch_exec;
  logic        mclk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [15:0] instr_in = 16'h0000;
  logic        instr_valid_in = 1'b0;
  logic        ext_set_en_in = 1'b0;
  logic [3:0]  bank_pointer_register_in = 4'h0;
  logic [11:0] index_base_in = 12'h000;
  logic [20:0] pc_in = 21'h00_0000;
  logic [7:0]  mem_rdata_in = 8'h00;
  logic [1:0]  phase_out;
  logic        instr_taken_out, mem_rd_out, mem_wr_out, pc_load_out, busy_out;
  logic [11:0] mem_addr_out;
  logic [7:0]  mem_wdata_out;
  logic [20:0] pc_target_out;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed = 51225;

  bit_set_and_branch_exec u_bit_set_and_branch_exec (
    .mclk_in(mclk_in), .srst_in(srst_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .ext_set_en_in(ext_set_en_in),
    .bank_pointer_register_in(bank_pointer_register_in),
    .index_base_in(index_base_in), .pc_in(pc_in),
    .mem_rdata_in(mem_rdata_in), .phase_out(phase_out),
    .instr_taken_out(instr_taken_out), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .pc_load_out(pc_load_out),
    .pc_target_out(pc_target_out), .busy_out(busy_out));

  always #5 mclk_in = ~mclk_in;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] exp_addr(logic [7:0] f, logic a, logic e,
                                           logic [3:0] bk, logic [11:0] bs);
    if (a) return {bk, f};
    if (f > 8'h5f) return {4'hf, f};
    return e ? bs + {4'h0, f} : {4'h0, f};
  endfunction : exp_addr

  // Offers one word for the next Q1 edge and returns at that edge.
  task automatic issue(input logic [15:0] w, input logic e,
                       input logic [3:0] bk, input logic [11:0] bs,
                       input logic [20:0] pc);
    int k;
    k = 0;
    do begin
      @(posedge mclk_in);
      #1;
      k++;
    end while (phase_out !== 2'h2 && k < 8);
    if (phase_out !== 2'h2) begin
      error_cnt++;
      results();
    end
    @(posedge mclk_in);
    instr_in <= w;
    instr_valid_in <= 1'b1;
    ext_set_en_in <= e;
    bank_pointer_register_in <= bk;
    index_base_in <= bs;
    pc_in <= pc;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    instr_in <= ~w;
  endtask : issue

  task automatic bsf(input logic [2:0] b, input logic a, input logic [7:0] f,
                     input logic [7:0] d, input logic e,
                     input logic [3:0] bk, input logic [11:0] bs);
    issue({4'h8, b, a, f}, e, bk, bs, 21'h00_0000);
    #1;
    chk(instr_taken_out, 1);
    chk(mem_rd_out, 1);
    chk(mem_addr_out, exp_addr(f, a, e, bk, bs));
    @(posedge mclk_in);
    mem_rdata_in <= d;
    @(posedge mclk_in);
    // Memory lets go after its slot, so the old byte must not be reused.
    mem_rdata_in <= ~d;
    #1;
    chk(mem_wr_out, 1);
    chk(mem_wdata_out, d | (8'h01 << b));
  endtask : bsf

  task automatic jmp(input logic [10:0] n, input logic [20:0] pc);
    issue({5'h1a, n}, 1'b0, 4'h0, 12'h000, pc);
    #1;
    chk(instr_taken_out, 1);
    chk(pc_target_out, 21'(pc + 21'h00_0002 + {{9{n[10]}}, n, 1'b0}));
    repeat (2) @(posedge mclk_in);
    #1;
    chk(pc_load_out, 1);
    chk(busy_out, 1);
    @(posedge mclk_in);
    instr_in <= 16'h8f00;
    instr_valid_in <= 1'b1;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    #1;
    chk(instr_taken_out, 0);
    chk(mem_rd_out, 0);
  endtask : jmp

  initial begin
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    bsf(3'h7, 1'b1, 8'h0a, 8'h0a, 1'b0, 4'h3, 12'h000);
    bsf(3'h0, 1'b0, 8'h5f, 8'hff, 1'b1, 4'h5, 12'hffa);
    bsf(3'h3, 1'b0, 8'h60, 8'h00, 1'b1, 4'h5, 12'h123);
    bsf(3'h1, 1'b0, 8'h5f, 8'h00, 1'b0, 4'h9, 12'h777);
    bsf(3'h2, 1'b0, 8'hff, 8'h04, 1'b0, 4'ha, 12'h000);
    $display("test bit set corners done");
    for (int i = 0; i < 40; i++) begin
      bsf($random(seed), $random(seed), $random(seed), $random(seed),
          $random(seed), $random(seed), $random(seed));
    end
    $display("test bit set random done");
    jmp(11'h400, 21'h1f_fffe);
    bsf(3'h4, 1'b1, 8'h33, 8'h10, 1'b0, 4'hf, 12'h000);
    jmp(11'h3ff, $random(seed));
    jmp($random(seed), $random(seed));
    $display("test jump done");
    // A reset in mid instruction must drop every strobe and restart at Q1.
    issue(16'h8a42, 1'b0, 4'h2, 12'h000, 21'h00_0000);
    srst_in <= 1'b1;
    @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk({phase_out, instr_taken_out, mem_rd_out, mem_wr_out}, 0);
    chk({pc_load_out, busy_out, mem_addr_out, mem_wdata_out}, 0);
    bsf(3'h5, 1'b0, 8'h42, 8'h81, 1'b0, 4'h2, 12'h000);
    $display("test mid reset done");
    issue(16'h9123, 1'b0, 4'h0, 12'h000, 21'h00_0000);
    #1;
    chk(instr_taken_out, 1);
    chk(mem_rd_out, 0);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(mem_wr_out, 0);
    chk(pc_load_out, 0);
    $display("test other opcode done");
    results();
  end
endmodule : tb_bit_set_and_branch_exec
